/* File: src/txpf_top.sv */
// Overview of operation
// - FIFO absorbs phase offset between fabric write side and parallel read side.
// - Normal mode holds four words, two to three parallel cycles latency.
// - Registered mode in deterministic latency skips the two read ticks of write pointer staging.
// - Word width follows configured channel width: 8, 10, 16 or 20 bits.
// - Byte serializer splits each 16 or 20 bit word into two half-width words, doubling rate.
// - With byte serializer on at 16 or 20 bits, FIFO read clock is bonded clock divided by two.
// - FIFO read clock is exported as coreclk_out; fabric launches transmit data with it.
`timescale 1ns/100ps
`default_nettype none

`include "txpf_consts.svh"

module txpf_top #(
  parameter int WORD_W = `TXPF_WORD_W_MAX,
  parameter int DEPTH = `TXPF_FIFO_DEPTH,
  parameter int PAR_DIV = `TXPF_PAR_DIV
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire txpf_pkg::txpf_width_t cfg_width,
  input wire logic cfg_byte_ser_en,
  input wire logic cfg_registered,
  input wire logic tx_wr_valid,
  input wire logic [WORD_W-1:0] tx_wr_data,
  output logic tx_wr_ready,
  output logic coreclk_out,
  output logic [WORD_W-1:0] tx_par_data,
  output logic tx_par_valid
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  localparam int PTR_W = `TXPF_PTR_W;

  if (WORD_W != `TXPF_WORD_W_MAX)
  begin : g_bad_width
    $error("WORD_W must be 20");
  end
  if (DEPTH != `TXPF_FIFO_DEPTH)
  begin : g_bad_depth
    $error("DEPTH must be 4");
  end
  if (PAR_DIV < 1 || PAR_DIV > 255)
  begin : g_bad_div
    $error("PAR_DIV out of range");
  end

  // ***************************************************************
  // Helper functions
  // ***************************************************************
  // Keep only the bits of the configured channel width
  function automatic logic [WORD_W-1:0] width_mask(input txpf_pkg::txpf_width_t w,
                                                   input logic [WORD_W-1:0] d);
    logic [WORD_W-1:0] m;
    case (w)
      txpf_pkg::TXPF_W8: m = WORD_W'(20'h000ff);
      txpf_pkg::TXPF_W10: m = WORD_W'(20'h003ff);
      txpf_pkg::TXPF_W16: m = WORD_W'(20'h0ffff);
      default: m = WORD_W'(20'hfffff);
    endcase
    return d & m;
  endfunction

  // Pointer increment with wrap over twice the depth
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return PTR_W'(p + 3'h1);
  endfunction

  // ***************************************************************
  // Bonded low-speed clock divider
  // ***************************************************************
  logic [7:0] div_cnt_q;
  logic par_tick;
  logic rd_phase_q;
  logic rd_tick;
  logic ser_active;

  assign par_tick = (div_cnt_q == 8'(PAR_DIV - 1));
  // Narrow words bypass the serializer, so their read rate must stay whole
  assign ser_active = cfg_byte_ser_en &&
                      ((cfg_width == txpf_pkg::TXPF_W16) || (cfg_width == txpf_pkg::TXPF_W20));
  assign rd_tick = par_tick && (!ser_active || rd_phase_q);

  // Divider from sys_clk to the parallel clock enable
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      div_cnt_q <= 8'h00;
      rd_phase_q <= 1'b0;
    end
    else if (par_tick)
    begin
      div_cnt_q <= 8'h00;
      rd_phase_q <= !rd_phase_q;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      coreclk_out <= 1'b0;
    else if (rd_tick)
      coreclk_out <= !coreclk_out;
  end

  // ***************************************************************
  // Phase compensation FIFO storage and write side
  // ***************************************************************
  logic [WORD_W-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wptr_q;
  logic [PTR_W-1:0] rptr_q;
  logic [PTR_W-1:0] wptr_d;
  logic [PTR_W-1:0] rptr_d;
  logic [PTR_W-1:0] fill_d;
  logic wr_fire;
  logic rd_fire;

  // Pointer updates and fill level after this cycle's activity
  assign wr_fire = tx_wr_valid && tx_wr_ready;
  assign wptr_d = wr_fire ? ptr_inc(wptr_q) : wptr_q;
  assign rptr_d = rd_fire ? ptr_inc(rptr_q) : rptr_q;
  assign fill_d = PTR_W'(wptr_d - rptr_d);

  always_ff @(posedge sys_clk)
  begin
    if (wr_fire)
      mem_q[wptr_q[PTR_W-2:0]] <= width_mask(cfg_width, tx_wr_data);
  end

  // ready only guards the four words
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      wptr_q <= '0;
      tx_wr_ready <= 1'b0;
    end
    else
    begin
      wptr_q <= wptr_d;
      tx_wr_ready <= (fill_d < PTR_W'(DEPTH));
    end
  end

  // ***************************************************************
  // Read side pointer view
  // ***************************************************************
  logic [PTR_W-1:0] wsync_q [`TXPF_SYNC_STAGES];
  logic [PTR_W-1:0] wptr_seen;
  logic [WORD_W-1:0] rd_word_q;
  logic rd_valid_q;

  // registered mode sees writes at once
  // normal mode waits two read ticks
  assign wptr_seen = cfg_registered ? wptr_q : wsync_q[`TXPF_SYNC_STAGES-1];
  assign rd_fire = rd_tick && (rptr_q != wptr_seen);

  // Write pointer staged on read clock ticks
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      wsync_q[0] <= '0;
      wsync_q[1] <= '0;
    end
    else if (rd_tick)
    begin
      wsync_q[0] <= wptr_q;
      wsync_q[1] <= wsync_q[0];
    end
  end

  // read word out on read clock ticks
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      rptr_q <= '0;
      rd_word_q <= '0;
      rd_valid_q <= 1'b0;
    end
    else if (rd_tick)
    begin
      rptr_q <= rptr_d;
      rd_valid_q <= rd_fire;
      rd_word_q <= rd_fire ? width_mask(cfg_width, mem_q[rptr_q[PTR_W-2:0]]) : '0;
    end
  end

  // ***************************************************************
  // Byte serializer
  // ***************************************************************
  // optional width halving
  txpf_byte_ser #(
    .WORD_W(WORD_W)
  ) u_byte_ser (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .par_tick(par_tick),
    .ser_en(cfg_byte_ser_en),
    .width(cfg_width),
    .in_word(rd_word_q),
    .in_valid(rd_valid_q),
    .out_word(tx_par_data),
    .out_valid(tx_par_valid)
  );

endmodule

`default_nettype wire

/* File: src/txpf_consts.svh */
`ifndef TXPF_CONSTS_SVH
`define TXPF_CONSTS_SVH

// ***************************************************************
// Datapath geometry
// ***************************************************************
`define TXPF_WORD_W_MAX 20
`define TXPF_FIFO_DEPTH 4
`define TXPF_PTR_W 3

// ***************************************************************
// Channel width selection codes (one-hot)
// ***************************************************************
`define TXPF_WIDTH_8 4'h1
`define TXPF_WIDTH_10 4'h2
`define TXPF_WIDTH_16 4'h4
`define TXPF_WIDTH_20 4'h8

// ***************************************************************
// Parallel clock timing
// ***************************************************************
`define TXPF_SYS_CLK_PERIOD_NS 25
`define TXPF_PAR_CLK_PERIOD_NS 50
`define TXPF_PAR_DIV (`TXPF_PAR_CLK_PERIOD_NS / `TXPF_SYS_CLK_PERIOD_NS)
`define TXPF_SYNC_STAGES 2

`endif

/* File: src/txpf_pkg.sv */
`default_nettype none

`include "txpf_consts.svh"

package txpf_pkg;

  // Configured channel width, one-hot
  typedef enum logic [3:0] {
    TXPF_W8 = `TXPF_WIDTH_8,
    TXPF_W10 = `TXPF_WIDTH_10,
    TXPF_W16 = `TXPF_WIDTH_16,
    TXPF_W20 = `TXPF_WIDTH_20
  } txpf_width_t;

  // Byte serializer half being sent, one-hot
  typedef enum logic [1:0] {
    TXPF_HALF_LOW = 2'h1,
    TXPF_HALF_HIGH = 2'h2
  } txpf_half_t;

endpackage

`default_nettype wire

/* File: src/txpf_byte_ser.sv */
`timescale 1ns/100ps
`default_nettype none

`include "txpf_consts.svh"

module txpf_byte_ser #(
  parameter int WORD_W = `TXPF_WORD_W_MAX
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic par_tick,
  input wire logic ser_en,
  input wire txpf_pkg::txpf_width_t width,
  input wire logic [WORD_W-1:0] in_word,
  input wire logic in_valid,
  output logic [WORD_W-1:0] out_word,
  output logic out_valid
);

  // ***************************************************************
  // Half-word splitting
  // ***************************************************************
  txpf_pkg::txpf_half_t half_q;
  txpf_pkg::txpf_half_t half_d;
  logic [WORD_W-1:0] hold_q;
  logic hold_valid_q;
  logic [WORD_W-1:0] high_half;
  logic [WORD_W-1:0] low_half;
  logic wide;

  // Only 16 and 20 bit words can be split; narrow widths pass through
  assign wide = (width == txpf_pkg::TXPF_W16) || (width == txpf_pkg::TXPF_W20);
  assign low_half = (width == txpf_pkg::TXPF_W20) ?
                    (in_word & WORD_W'(20'h003ff)) : (in_word & WORD_W'(20'h000ff));
  assign high_half = (width == txpf_pkg::TXPF_W20) ?
                     ((hold_q >> 10) & WORD_W'(20'h003ff)) : ((hold_q >> 8) & WORD_W'(20'h000ff));

  // Phase alternates on every parallel tick while splitting
  always_comb
  begin
    case (half_q)
      txpf_pkg::TXPF_HALF_LOW: half_d = txpf_pkg::TXPF_HALF_HIGH;
      txpf_pkg::TXPF_HALF_HIGH: half_d = txpf_pkg::TXPF_HALF_LOW;
      default: half_d = txpf_pkg::TXPF_HALF_LOW;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      half_q <= txpf_pkg::TXPF_HALF_LOW;
      hold_q <= '0;
      hold_valid_q <= 1'b0;
      out_word <= '0;
      out_valid <= 1'b0;
    end
    else if (par_tick)
    begin
      if (!ser_en || !wide)
      begin
        half_q <= txpf_pkg::TXPF_HALF_LOW;
        out_word <= in_word;
        out_valid <= in_valid;
      end
      else if (half_q == txpf_pkg::TXPF_HALF_LOW)
      begin
        half_q <= half_d;
        hold_q <= in_word;
        hold_valid_q <= in_valid;
        out_word <= low_half;
        out_valid <= in_valid;
      end
      else
      begin
        half_q <= half_d;
        out_word <= high_half;
        out_valid <= hold_valid_q;
      end
    end
  end

endmodule

`default_nettype wire

/* File: testbench/txpf_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ***
// Output checks
// ***
module txpf_chk #(
  parameter int WORD_W = 20
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire txpf_pkg::txpf_width_t cfg_width,
  input wire logic cfg_byte_ser_en,
  input wire logic cfg_registered,
  input wire logic tx_wr_valid,
  input wire logic tx_wr_ready,
  input wire logic coreclk_out,
  input wire logic [WORD_W-1:0] tx_par_data,
  input wire logic tx_par_valid
);
  // One clock domain for all checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  property p_w8;
    cfg_width == txpf_pkg::TXPF_W8 |-> tx_par_data[19:8] == 12'h000;
  endproperty
  a_w8: assert property (p_w8) else $error("w8 upper bits");
  property p_w10;
    cfg_width == txpf_pkg::TXPF_W10 |-> tx_par_data[19:10] == 10'h000;
  endproperty
  a_w10: assert property (p_w10) else $error("w10 upper bits");
  property p_half;
    cfg_byte_ser_en && cfg_width == txpf_pkg::TXPF_W16 |-> tx_par_data[19:8] == 12'h000;
  endproperty
  a_half: assert property (p_half) else $error("half upper bits");
  property p_clk_off;
    !(cfg_byte_ser_en && (cfg_width == txpf_pkg::TXPF_W16 || cfg_width == txpf_pkg::TXPF_W20)) &&
      $changed(coreclk_out) |=> $stable(coreclk_out) ##1 $changed(coreclk_out);
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock rate");
  property p_clk_ser;
    cfg_byte_ser_en && (cfg_width == txpf_pkg::TXPF_W16 || cfg_width == txpf_pkg::TXPF_W20) &&
      $changed(coreclk_out) |=> $stable(coreclk_out)[*3] ##1 $changed(coreclk_out);
  endproperty
  a_clk_ser: assert property (p_clk_ser) else $error("halved clock");
  property p_hold;
    $rose(tx_par_valid) |=> tx_par_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("word too short");
  property p_lat;
    cfg_registered && tx_wr_valid && tx_wr_ready |-> ##[1:10] tx_par_valid;
  endproperty
  a_lat: assert property (p_lat) else $error("registered latency");
endmodule
bind txpf_top txpf_chk #(.WORD_W(WORD_W)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .cfg_width(cfg_width), .cfg_byte_ser_en(cfg_byte_ser_en), .cfg_registered(cfg_registered),
  .tx_wr_valid(tx_wr_valid), .tx_wr_ready(tx_wr_ready), .coreclk_out(coreclk_out),
  .tx_par_data(tx_par_data), .tx_par_valid(tx_par_valid));
`default_nettype wire

/* File: testbench/txpf_src.sv */
`timescale 1ns/100ps
`default_nettype none
// ***
// Fabric source
// ***
module txpf_src (
  input wire logic sys_clk,
  input wire logic coreclk_out,
  input wire logic tx_wr_ready,
  output logic tx_wr_valid,
  output logic [19:0] tx_wr_data
);
  int stalls = 0;
  // Idle bus at time zero
  initial
  begin
    tx_wr_valid = 1'b0;
    tx_wr_data = 20'h00000;
  end
  // Released data shows the inverse word
  task automatic idle();
    tx_wr_valid <= 1'b0;
    tx_wr_data <= ~tx_wr_data;
  endtask
  // paced sends launch once per exported clock edge; unpaced sends launch back to back
  task automatic send(input logic [19:0] w, input bit paced);
    if (paced)
    begin
      idle();
      @(negedge sys_clk);
      @(coreclk_out);
    end
    tx_wr_valid <= 1'b1;
    tx_wr_data <= w;
    @(posedge sys_clk);
    while (tx_wr_ready !== 1'b1)
    begin
      stalls++;
      @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_tx_phase_fifo_byte_serializer.sv */
`timescale 1ns/100ps
`default_nettype none
// ***
// Testbench
// ***
module tb_tx_phase_fifo_byte_serializer;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  txpf_pkg::txpf_width_t cfg_width = txpf_pkg::TXPF_W8;
  logic cfg_byte_ser_en = 1'b0;
  logic cfg_registered = 1'b0;
  logic tx_wr_valid;
  logic [19:0] tx_wr_data;
  logic tx_wr_ready;
  logic coreclk_out;
  logic [19:0] tx_par_data;
  logic tx_par_valid;
  logic [19:0] exp_q[$];
  logic ph = 1'b0;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int lat[8];
  int n;
  txpf_top dut_u (.sys_clk(sys_clk), .nrst(nrst), .cfg_width(cfg_width),
    .cfg_byte_ser_en(cfg_byte_ser_en), .cfg_registered(cfg_registered),
    .tx_wr_valid(tx_wr_valid), .tx_wr_data(tx_wr_data), .tx_wr_ready(tx_wr_ready),
    .coreclk_out(coreclk_out), .tx_par_data(tx_par_data), .tx_par_valid(tx_par_valid));
  txpf_src u_src (.sys_clk(sys_clk), .coreclk_out(coreclk_out), .tx_wr_ready(tx_wr_ready),
    .tx_wr_valid(tx_wr_valid), .tx_wr_data(tx_wr_data));
  // Clock and hang guard
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      $display("[FAIL] cycle limit expected %0d seen %0d", 4999, cyc);
      report_and_stop();
    end
  end
  // Monitor takes one note per parallel tick
  always @(negedge sys_clk)
  begin
    if (tx_par_valid !== 1'b1)
      ph = 1'b0;
    else
    begin
      if (!ph)
      begin
        checked++;
        if (exp_q.size() == 0 || tx_par_data !== exp_q[0])
        begin
          fails++;
          $display("[FAIL] tx_par_data expected %h seen %h", exp_q[0], tx_par_data);
        end
        if (exp_q.size() != 0)
          void'(exp_q.pop_front());
      end
      ph = ~ph;
    end
  end
  task automatic chk(input string nm, input int e, input int s);
    checked++;
    if (s != e)
    begin
      fails++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, s);
    end
  endtask
  task automatic restart(input int t);
    nrst <= 1'b0;
    cfg_width <= txpf_pkg::txpf_width_t'(4'h1 << (t < 4 ? t : t < 6 ? t - 2 : t - 6));
    cfg_byte_ser_en <= (t > 3);
    cfg_registered <= t[0];
    exp_q.delete();
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
  // Send a word and note its expected word, or its halves when split
  task automatic put(input logic [19:0] w, input bit paced);
    logic [19:0] m;
    m = cfg_width[0] ? 20'h000ff : cfg_width[1] ? 20'h003ff : cfg_width[2] ? 20'h0ffff : 20'hfffff;
    u_src.send(w, paced);
    if (cfg_byte_ser_en && m[15])
    begin
      exp_q.push_back(w & (m >> (m[16] ? 10 : 8)));
      exp_q.push_back((w & m) >> (m[16] ? 10 : 8));
    end
    else
      exp_q.push_back(w & m);
  endtask
  task automatic drain(input int t);
    repeat (200) if (exp_q.size() != 0) @(posedge sys_clk);
    chk("words left", 0, exp_q.size());
    $display("test %0d done", t);
  endtask
  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Width, mode and serializer sweep, then a burst
  initial
  begin
    void'($urandom(69));
    repeat (3) @(posedge sys_clk);
    for (int t = 0; t < 8; t++)
    begin
      restart(t);
      put(20'($urandom), 1'b1);
      u_src.idle();
      n = cyc;
      repeat (40) if (tx_par_valid !== 1'b1) @(posedge sys_clk);
      lat[t] = cyc - n;
      if (t[0])
        chk("latency gap", 1, int'(lat[t-1] - lat[t] >= 2));
      repeat (5) put(20'($urandom), 1'b1);
      u_src.idle();
      drain(t);
    end
    restart(2);
    u_src.stalls = 0;
    n = 0;
    repeat (12)
    begin
      put(20'($urandom), 1'b0);
      n += (u_src.stalls == 0);
    end
    u_src.idle();
    chk("words before stall", 1, int'(n >= 4 && u_src.stalls > 0));
    drain(8);
    report_and_stop();
  end
endmodule
`default_nettype wire
